// file: verilog/ivs_pkg.sv
// constants for the interrupt vector select block
package ivs_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IVS_EXT_CTRL_OFS   = 8'h08;
    localparam logic [7:0]  IVS_PEND_OFS       = 8'h0C;
    localparam logic [7:0]  IVS_VEC_OFS        = 8'h10;
    localparam logic [7:0]  IVS_EXT_CTRL_RST   = 8'h00;
    localparam logic [7:0]  IVS_PEND_SRC_OFS   = 8'h14;
    // ------------------------------------------------------------------
    // source indices, lowest vector first
    // ------------------------------------------------------------------
    localparam int          IVS_NSRC           = 9;
    localparam int          IVS_SRC_USB        = 0;
    localparam int          IVS_SRC_SERIAL     = 1;
    localparam int          IVS_SRC_I2C        = 2;
    localparam int          IVS_SRC_TIMER      = 3;
    localparam int          IVS_SRC_PIN        = 4;
    localparam int          IVS_SRC_USB_WAKE   = 5;
    localparam int          IVS_SRC_FLASH      = 6;
    localparam int          IVS_SRC_TRAP       = 7;
    localparam int          IVS_SRC_RESET      = 8;
    // vector base of source 0 and step between sources
    localparam logic [15:0] IVS_VEC_BASE       = 16'hFFEE;
    localparam logic [15:0] IVS_VEC_STEP       = 16'h0002;
    // sources gated by the cpu global mask bit
    localparam logic [8:0]  IVS_MASKABLE       = 9'h07F;
    // sources allowed to end halt
    localparam logic [8:0]  IVS_HALT_WAKE      = 9'h170;
    // idle source code when nothing is pending
    localparam logic [3:0]  IVS_SRC_NONE       = 4'hF;
endpackage : ivs_pkg

// file: verilog/ivs_top.sv
// interrupt vector select and halt wake-up logic with an ahb-lite slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ivs_top
    import ivs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // request sources, same clock domain
    input  wire logic        usb_req,
    input  wire logic        serial_req,
    input  wire logic        i2c_req,
    input  wire logic        timer_req,
    input  wire logic [7:0]  pin_req,
    input  wire logic        usb_wake_req,
    input  wire logic        flash_req,
    input  wire logic        trap_req,
    input  wire logic        reset_req,
    // cpu core side
    input  wire logic        global_mask,
    input  wire logic        halted,
    output logic             irq_valid,
    output logic      [15:0] irq_vector,
    output logic      [3:0]  irq_source,
    output logic             halt_wake
);
    import ivs_pkg::*;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // vector address of a source index
    function automatic logic [15:0] ivs_vec_of(input logic [3:0] idx);
        ivs_vec_of = IVS_VEC_BASE + ({12'h000, idx} << 1);
    endfunction : ivs_vec_of

    // highest set index wins, none gives the idle code
    function automatic logic [3:0] ivs_pick(input logic [8:0] req);
        logic [3:0] sel;
        sel = IVS_SRC_NONE;
        for (int i = 0; i < IVS_NSRC; i++)
            if (req[i])
                sel = 4'(i);
        ivs_pick = sel;
    endfunction : ivs_pick

    // ------------------------------------------------------------------
    // source gathering and masking
    // ------------------------------------------------------------------
    logic [7:0] ext_ctrl_q;
    logic [8:0] raw_req;
    logic [8:0] live_req;
    logic [8:0] wake_req;
    logic       pin_any;
    logic [3:0] win_idx;

    // pin lines enabled by the control register merge into one request
    assign pin_any  = |(pin_req & ext_ctrl_q);
    assign raw_req  = {reset_req, trap_req, flash_req,
                       usb_wake_req, pin_any, timer_req,
                       i2c_req, serial_req, usb_req};
    // maskable sources drop while the global mask bit is set
    assign live_req = raw_req & ~(IVS_MASKABLE & {9{global_mask}});
    // wake ignores the mask only for reset; masked wake sources stay off
    assign wake_req = live_req & IVS_HALT_WAKE;
    assign win_idx  = ivs_pick(live_req);

    // winner decode kept as named wires so the register stays a plain copy
    logic        win_valid;
    logic [15:0] win_vec;
    logic        wake_any;

    assign win_valid = (win_idx != IVS_SRC_NONE);
    assign win_vec   = win_valid ? ivs_vec_of(win_idx)
                                 : 16'h0000;
    assign wake_any  = halted & (|wake_req);

    // registered vector presented to the cpu, one cycle behind the sources
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_valid  <= 1'b0;
            irq_source <= IVS_SRC_NONE;
            irq_vector <= 16'h0000;
            halt_wake  <= 1'b0;
        end
        else
        begin
            irq_valid  <= win_valid;
            irq_source <= win_idx;
            irq_vector <= win_vec;
            halt_wake  <= wake_any;
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    logic       ph_wr_q;
    logic       ph_rd_q;
    logic [7:0] ph_addr_q;
    logic       take;
    logic [31:0] rd_mux;

    assign take      = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // capture the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_q   <= 1'b0;
            ph_rd_q   <= 1'b0;
            ph_addr_q <= 8'h00;
        end
        else
        begin
            ph_wr_q   <= take & hwrite;
            ph_rd_q   <= take & ~hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end

    // control register write in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ext_ctrl_q <= IVS_EXT_CTRL_RST;
        else if (ph_wr_q && ph_addr_q == IVS_EXT_CTRL_OFS)
            ext_ctrl_q <= hwdata[7:0];
    end

    // a write in the data phase lands in the pin enable register
    chk_ctrl_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ph_wr_q && ph_addr_q == IVS_EXT_CTRL_OFS
        |=> ext_ctrl_q == $past(hwdata[7:0]))
        else $error("control register write lost");

    // read decode; unmapped words read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (ph_addr_q)
            IVS_EXT_CTRL_OFS: rd_mux = {24'h000000, ext_ctrl_q};
            IVS_PEND_OFS:     rd_mux = {23'h000000, raw_req};
            IVS_VEC_OFS:      rd_mux = {15'h0000, irq_valid, irq_vector};
            IVS_PEND_SRC_OFS: rd_mux = {28'h0000000, irq_source};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end
    assign hrdata = ph_rd_q ? rd_mux : 32'h0000_0000;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // each check except chk_vector_pair looks one edge ahead: all cpu side outputs are registered
    // and follow the sampled sources by exactly one cycle

    // ------------------------------------------------------------------
    // peripheral sources
    // ------------------------------------------------------------------
    // the global mask bit leaves only trap and reset at the cpu
    chk_mask_blocks: assert property (
        @(posedge hclk) disable iff (!hresetn)
        global_mask && !trap_req && !reset_req |=> !irq_valid)
        else $error("masked request reached the cpu");

    // peripheral requests alone never end halt
    chk_peri_nowake: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (raw_req[8:4] == 5'h00) |=> !halt_wake)
        else $error("peripheral request ended halt");

    // usb request alone takes the lowest vector
    chk_usb_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && usb_req && raw_req[8:1] == 8'h00
        |=> irq_vector == 16'hFFEE)
        else $error("usb vector wrong");

    // serial port above usb
    chk_serial_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && serial_req && raw_req[8:2] == 7'h00
        |=> irq_vector == 16'hFFF0)
        else $error("serial vector wrong");

    // two-wire bus above serial port
    chk_i2c_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && i2c_req && raw_req[8:3] == 6'h00
        |=> irq_vector == 16'hFFF2)
        else $error("i2c vector wrong");

    // timer is the highest peripheral vector
    chk_timer_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && timer_req && raw_req[8:4] == 5'h00
        |=> irq_vector == 16'hFFF4)
        else $error("timer vector wrong");

    // the reserved area below the table is never vectored
    chk_vector_pair: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq_valid |-> irq_vector >= 16'hFFEE && irq_vector[0] == 1'b0)
        else $error("vector outside the table");

    // ------------------------------------------------------------------
    // wake-capable external and flash sources
    // ------------------------------------------------------------------
    // enabled pin lines share one vector
    chk_pin_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && pin_any && raw_req[8:5] == 4'h0
        |=> irq_vector == 16'hFFF6)
        else $error("pin vector wrong");

    // an unmasked pin request ends halt
    chk_pin_wake: assert property (
        @(posedge hclk) disable iff (!hresetn)
        halted && !global_mask && pin_any |=> halt_wake)
        else $error("pin request failed to wake");

    // usb suspend end above the pin lines
    chk_usbw_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && usb_wake_req && raw_req[8:6] == 3'h0
        |=> irq_vector == 16'hFFF8)
        else $error("usb wake vector wrong");

    // flash programming start below trap
    chk_flash_vector: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !global_mask && flash_req && raw_req[8:7] == 2'h0
        |=> irq_vector == 16'hFFFA)
        else $error("flash vector wrong");

    // an unmasked flash request ends halt
    chk_flash_wake: assert property (
        @(posedge hclk) disable iff (!hresetn)
        halted && !global_mask && flash_req |=> halt_wake)
        else $error("flash request failed to wake");

    // with the mask bit set only reset may end halt
    chk_wake_masked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        global_mask && !reset_req |=> !halt_wake)
        else $error("masked source ended halt");

    // no wake is signalled while the cpu runs
    chk_awake_quiet: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !halted |=> !halt_wake)
        else $error("wake while not halted");

    // ------------------------------------------------------------------
    // cpu sources and idle
    // ------------------------------------------------------------------
    // trap ignores the mask bit
    chk_trap_unmasked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        trap_req && !reset_req |=> irq_vector == 16'hFFFC)
        else $error("trap vector wrong or masked");

    // trap reports its own source code
    chk_trap_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        trap_req && !reset_req |=> irq_source == 4'h7)
        else $error("trap source code wrong");

    // trap alone never ends halt
    chk_trap_nowake: assert property (
        @(posedge hclk) disable iff (!hresetn)
        trap_req && raw_req[8] == 1'b0 && raw_req[6:4] == 3'h0
        |=> !halt_wake)
        else $error("trap ended halt");

    // reset wins over everything and always ends halt
    chk_reset_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        reset_req |=> irq_vector == 16'hFFFE && halt_wake == $past(halted))
        else $error("reset vector or wake wrong");

    // nothing pending gives the idle outputs
    chk_idle_code: assert property (
        @(posedge hclk) disable iff (!hresetn)
        raw_req == 9'h000
        |=> !irq_valid && irq_source == 4'hF && irq_vector == 16'h0000)
        else $error("idle outputs wrong");
endmodule : ivs_top
`default_nettype wire

// file: testbench/ivs_cpu_model.sv
// cpu core model owning the global mask bit and the halt state
`timescale 1ns/1ns
`default_nettype none
module ivs_cpu_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic mask_cmd,
    input  wire logic halt_cmd,
    input  wire logic halt_wake,
    output logic      global_mask,
    output logic      halted
);
    // mask follows the command, halt is left only on a wake
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            global_mask <= 1'b0;
            halted      <= 1'b0;
        end
        else
        begin
            global_mask <= mask_cmd;
            halted      <= halt_wake ? 1'b0 : (halted | halt_cmd);
        end
    end
endmodule : ivs_cpu_model
`default_nettype wire

// file: testbench/test_interrupt_vector_select.sv
// self-checking bench for the interrupt vector select block
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_vector_select;
    import ivs_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, mask_cmd, halt_cmd;
    logic        hreadyout, irq_valid, halt_wake, global_mask, halted, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, ev, es, ea, ek;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [8:0]  src;
    logic [7:0]  pin_req, ctrl;
    logic [15:0] irq_vector;
    logic [3:0]  irq_source;
    wire logic   hready = hreadyout;
    int          fails, compares;
    ivs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .usb_req(src[0]), .serial_req(src[1]), .i2c_req(src[2]),
        .timer_req(src[3]), .pin_req(pin_req), .usb_wake_req(src[5]),
        .flash_req(src[6]), .trap_req(src[7]), .reset_req(src[8]),
        .global_mask(global_mask), .halted(halted), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .irq_source(irq_source),
        .halt_wake(halt_wake));
    ivs_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .mask_cmd(mask_cmd),
        .halt_cmd(halt_cmd), .halt_wake(halt_wake),
        .global_mask(global_mask), .halted(halted));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // waits for hready at a rising edge, data seen just before that edge
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        for (int i = 0; i < 50; i++)
        begin
            @(negedge hclk);
            r = hreadyout;
            d = hrdata;
            @(posedge hclk);
            if (r === 1'b1)
                return;
        end
        fails++;
        complete_run();
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
    endtask : bus
    // reference: highest unmasked source wins, wake only while halted
    task automatic expect_irq;
        logic [8:0] eff;
        eff = {src[8:5], |(pin_req & ctrl), src[3:0]};
        if (global_mask === 1'b1)
            eff = eff & 9'h180;
        ev = 32'h0;
        es = 32'hF;
        for (int w = 0; w < 9; w++)
            if (eff[w])
            begin
                ev = 32'hFFEE + 2 * w;
                es = w;
            end
        ea = {31'h0, eff != 9'h0};
        ek = {31'h0, halted === 1'b1 && (eff & 9'h170) != 9'h0};
    endtask : expect_irq
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial
    begin
        int n;
        {hresetn, hsel, hwrite, mask_cmd, halt_cmd, src, pin_req} = '0;
        {haddr, hwdata, htrans, ctrl} = '0;
        hsize = 3'h2;
        n = $urandom(41040);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h08, 32'h0, rd);
        check(rd, 32'h0);
        check({26'h0, irq_valid, halt_wake, irq_source}, 32'hF);
        for (n = 0; n < 8; n++)
        begin
            ctrl = 8'($urandom);
            bus(1'b1, 8'h08, {24'h0, ctrl}, rd);
            bus(1'b0, 8'h08, 32'h0, rd);
            check(rd, {24'h0, ctrl});
            repeat (60)
            begin
                @(posedge hclk);
                src <= 9'($urandom & $urandom & $urandom);
                pin_req <= 8'($urandom & $urandom);
                mask_cmd <= 1'($urandom);
                halt_cmd <= 1'($urandom);
                @(negedge hclk);
                expect_irq();
                @(posedge hclk);
                #1;
                check({31'h0, irq_valid}, ea);
                check({16'h0, irq_vector}, ev);
                check({28'h0, irq_source}, es);
                check({31'h0, halt_wake}, ek);
            end
            repeat (2) @(posedge hclk);
            expect_irq();
            bus(1'b0, 8'h10, 32'h0, rd);
            check(rd, {ea[15:0], ev[15:0]});
            bus(1'b0, 8'h14, 32'h0, rd);
            check(rd, es);
            bus(1'b0, 8'h0C, 32'h0, rd);
            check(rd, {23'h0, src[8:5], |(pin_req & ctrl), src[3:0]});
            check({31'h0, hresp}, 32'h0);
            $display("round %0d done", n);
        end
        // mid-run reset: outputs idle at once, pin enables cleared
        hresetn <= 1'b0;
        ctrl = 8'h00;
        repeat (2) @(posedge hclk);
        #1;
        check({26'h0, irq_valid, halt_wake, irq_source}, 32'hF);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h08, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, 8'h30, 32'h0, rd);
        check(rd, 32'h0);
        $display("reset test done");
        complete_run();
    end
endmodule : test_interrupt_vector_select
`default_nettype wire
